// ===== inc/pwm_map.vh
// Register offsets, field positions, reset values and timing for the PWM
`ifndef PWM_MAP_VH
`define PWM_MAP_VH

// ==========================================================
// Register byte offsets (one aligned 32-bit word each)
`define OFS_PWM_CONTROL 8'h00
`define OFS_DUTY_WRITE 8'h04
`define OFS_DUTY_SHADOW 8'h08
`define OFS_IRQ_ENABLES 8'h0C
`define OFS_IRQ_FLAGS 8'h10
`define OFS_PERIOD_LIMIT 8'h14
`define OFS_TIMER_CONTROL 8'h18
`define OFS_TIMER_COUNT 8'h1C
`define OFS_PIN_DIRECTION 8'h20
`define OFS_PORT_LATCH 8'h24

// ==========================================================
// Field positions
`define MODE_LO 0
`define MODE_HI 3
`define DUTY_LOW_LO 4
`define DUTY_LOW_HI 5
`define PRESCALE_LO 0
`define PRESCALE_HI 1
`define TIMER_RUN_BIT 2
`define POSTSCALE_LO 3
`define POSTSCALE_HI 6
`define TIMER_MATCH_BIT 1
`define PIN_DIR_BIT 0
`define PORT_DATA_BIT 0

// ==========================================================
// Encodings and reset values
`define PWM_MODE_TAG 2'h3
`define PRESCALE_1 2'h0
`define PRESCALE_4 2'h1
`define RST_BYTE 8'h00
`define RST_PERIOD 8'hFF
`define RST_PIN_DIR 8'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================================
// Timing: system clocks per timer increment at 1:1
`define CLKS_PER_INC 4
`define PRESCALE_MAX 16

`endif

// ===== verilog/standard_pwm.v
// Standard single-output PWM with timer, period and duty compare
`timescale 1ns/1ps
`include "pwm_map.vh"

module standard_pwm
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleep,
  output reg pwm_out_pin,
  output reg pwm_out_pin_oe
);

  // ==========================================================
  // Register state
  reg [7:0] pwm_control_ff;
  reg [7:0] duty_write_ff;
  reg [7:0] duty_shadow_ff;
  reg [1:0] duty_latch_ff;
  reg [7:0] irq_enables_ff;
  reg [7:0] irq_flags_ff;
  reg [7:0] period_limit_ff;
  reg [7:0] timer_control_ff;
  reg [7:0] timer_count_ff;
  reg [7:0] pin_direction_ff;
  reg [7:0] port_latch_ff;
  reg [5:0] prescale_ff;
  reg [3:0] postscale_ff;
  reg pwm_level_ff;

  // Bus handshake state
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] wr_addr_ff;
  reg [7:0] wr_data_ff;
  reg wr_strb_ff;

  wire pwm_mode;
  wire [1:0] pre_sel;
  wire [5:0] pre_last;
  wire [1:0] base_low;
  wire [9:0] time_base;
  wire [9:0] duty_cmp;
  wire [9:0] duty_next;
  wire run;
  wire inc_tick;
  wire period_roll;
  wire post_hit;
  wire do_write;
  wire duty_hit;
  wire rd_hit;

  // Returns true when an offset belongs to the register map
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFS_PWM_CONTROL) || (a == `OFS_DUTY_WRITE) ||
               (a == `OFS_DUTY_SHADOW) || (a == `OFS_IRQ_ENABLES) ||
               (a == `OFS_IRQ_FLAGS) || (a == `OFS_PERIOD_LIMIT) ||
               (a == `OFS_TIMER_CONTROL) || (a == `OFS_TIMER_COUNT) ||
               (a == `OFS_PIN_DIRECTION) || (a == `OFS_PORT_LATCH);
    end
  endfunction

  // Register read multiplexer
  function [7:0] read_mux;
    input [7:0] a;
    begin
      if (a == `OFS_PWM_CONTROL)
        read_mux = pwm_control_ff;
      else if (a == `OFS_DUTY_WRITE)
        read_mux = duty_write_ff;
      else if (a == `OFS_DUTY_SHADOW)
        read_mux = duty_shadow_ff;
      else if (a == `OFS_IRQ_ENABLES)
        read_mux = irq_enables_ff;
      else if (a == `OFS_IRQ_FLAGS)
        read_mux = irq_flags_ff;
      else if (a == `OFS_PERIOD_LIMIT)
        read_mux = period_limit_ff;
      else if (a == `OFS_TIMER_CONTROL)
        read_mux = timer_control_ff;
      else if (a == `OFS_TIMER_COUNT)
        read_mux = timer_count_ff;
      else if (a == `OFS_PIN_DIRECTION)
        read_mux = pin_direction_ff;
      else if (a == `OFS_PORT_LATCH)
        read_mux = port_latch_ff;
      else
        read_mux = 8'h00;
    end
  endfunction

  // ==========================================================
  // Time base
  assign pwm_mode = (pwm_control_ff[`MODE_HI:`MODE_HI-1] == `PWM_MODE_TAG);
  assign pre_sel = timer_control_ff[`PRESCALE_HI:`PRESCALE_LO];

  // Last prescaler count per ratio: 4, 16 or 64 clocks per step
  assign pre_last = (pre_sel == `PRESCALE_1) ? 6'h03 :
                    (pre_sel == `PRESCALE_4) ? 6'h0F : 6'h3F;

  // Low two base bits from clock divider at 1:1, else prescaler
  assign base_low = (pre_sel == `PRESCALE_1) ? prescale_ff[1:0] :
                    (pre_sel == `PRESCALE_4) ? prescale_ff[3:2] :
                    prescale_ff[5:4];
  assign time_base = {timer_count_ff, base_low};
  assign duty_cmp = {duty_shadow_ff, duty_latch_ff};
  assign duty_next = {duty_write_ff,
                      pwm_control_ff[`DUTY_LOW_HI:`DUTY_LOW_LO]};

  // Sleep freezes every counter; run bit gates the timer
  assign run = timer_control_ff[`TIMER_RUN_BIT] && !sleep;
  assign inc_tick = run && (prescale_ff == pre_last);
  assign period_roll = inc_tick &&
                       (timer_count_ff == period_limit_ff);
  assign post_hit = (postscale_ff ==
                     timer_control_ff[`POSTSCALE_HI:`POSTSCALE_LO]);

  // Duty match, true in the cycle the time base reaches the duty value
  assign duty_hit = run && (time_base == duty_cmp);

  // ==========================================================
  // Bus slave handshakes
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign rd_hit = mapped(s_axi_araddr);

  // Write address and data capture in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      wr_strb_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        wr_addr_ff <= s_axi_awaddr;
      end
      else if (do_write)
        aw_got_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wr_data_ff <= s_axi_wdata[7:0];
        wr_strb_ff <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_got_ff <= 1'b0;
    end
  end

  // Write response follows the performed write
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(wr_addr_ff) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read data one cycle after the address is taken; the mux is
  // evaluated at the edge so it always sees the live registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, read_mux(s_axi_araddr)};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Plain software registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_control_ff <= `RST_BYTE;
      duty_write_ff <= `RST_BYTE;
      irq_enables_ff <= `RST_BYTE;
      period_limit_ff <= `RST_PERIOD;
      timer_control_ff <= `RST_BYTE;
      pin_direction_ff <= `RST_PIN_DIR;
      port_latch_ff <= `RST_BYTE;
    end
    else if (do_write && wr_strb_ff)
    begin
      if (wr_addr_ff == `OFS_PWM_CONTROL)
        pwm_control_ff <= wr_data_ff;
      else if (wr_addr_ff == `OFS_DUTY_WRITE)
        duty_write_ff <= wr_data_ff;
      else if (wr_addr_ff == `OFS_IRQ_ENABLES)
        irq_enables_ff <= wr_data_ff;
      else if (wr_addr_ff == `OFS_PERIOD_LIMIT)
        period_limit_ff <= wr_data_ff;
      else if (wr_addr_ff == `OFS_TIMER_CONTROL)
        timer_control_ff <= wr_data_ff;
      else if (wr_addr_ff == `OFS_PIN_DIRECTION)
        pin_direction_ff <= wr_data_ff;
      else if (wr_addr_ff == `OFS_PORT_LATCH)
        port_latch_ff <= wr_data_ff;
    end
  end

  // ==========================================================
  // Prescaler and timer count; a software timer write restarts the step
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescale_ff <= 6'h00;
      timer_count_ff <= `RST_BYTE;
    end
    else if (do_write && wr_strb_ff && (wr_addr_ff == `OFS_TIMER_COUNT))
    begin
      prescale_ff <= 6'h00;
      timer_count_ff <= wr_data_ff;
    end
    else if (inc_tick)
    begin
      prescale_ff <= 6'h00;
      if (period_roll)
        timer_count_ff <= 8'h00;
      else
        timer_count_ff <= timer_count_ff + 8'h01;
    end
    else if (run)
      prescale_ff <= prescale_ff + 6'h01;
  end

  // Postscaler counts period matches and paces only the flag;
  // a software timer write restarts it so a new setting starts clean
  always @(posedge aclk)
  begin
    if (!aresetn)
      postscale_ff <= 4'h0;
    else if (do_write && wr_strb_ff && (wr_addr_ff == `OFS_TIMER_COUNT))
      postscale_ff <= 4'h0;
    else if (period_roll)
      postscale_ff <= post_hit ? 4'h0 : postscale_ff + 4'h1;
  end

  // Match flag: hardware set wins over a software write
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_flags_ff <= `RST_BYTE;
    else
    begin
      if (do_write && wr_strb_ff && (wr_addr_ff == `OFS_IRQ_FLAGS))
        irq_flags_ff <= wr_data_ff;
      if (period_roll && post_hit)
        irq_flags_ff[`TIMER_MATCH_BIT] <= 1'b1;
    end
  end

  // ==========================================================
  // Duty shadow: loaded at each period boundary, locked in PWM mode
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      duty_shadow_ff <= `RST_BYTE;
      duty_latch_ff <= 2'h0;
    end
    else if (period_roll)
    begin
      duty_shadow_ff <= duty_next[9:2];
      duty_latch_ff <= duty_next[1:0];
    end
    else if (do_write && wr_strb_ff && !pwm_mode &&
             (wr_addr_ff == `OFS_DUTY_SHADOW))
      duty_shadow_ff <= wr_data_ff;
  end

  // Output level: set at period start unless the duty is zero, cleared on duty match
  always @(posedge aclk)
  begin
    if (!aresetn)
      pwm_level_ff <= 1'b0;
    else if (!pwm_mode)
      pwm_level_ff <= 1'b0;
    else if (period_roll)
      pwm_level_ff <= (duty_next != 10'h000);
    else if (duty_hit)
      pwm_level_ff <= 1'b0;
  end

  // Pin drive: PWM level in PWM mode, otherwise the port latch;
  // a duty match drops the pin at once so high time equals the duty
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_out_pin <= 1'b0;
      pwm_out_pin_oe <= 1'b0;
    end
    else
    begin
      pwm_out_pin <= pwm_mode ? (pwm_level_ff && !duty_hit) :
                     port_latch_ff[`PORT_DATA_BIT];
      pwm_out_pin_oe <= !pin_direction_ff[`PIN_DIR_BIT];
    end
  end

endmodule // standard_pwm

// ===== verif/standard_pwm_sva.sv
// Checker for bus handshakes, reset and sleep of the PWM block
`timescale 1ns/1ps
module standard_pwm_sva
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleep,
  input wire pwm_out_pin,
  input wire pwm_out_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Steps of a write and of a sleep spell
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence asleep;
    sleep [*3];
  endsequence
  // ==========================================================
  // Properties
  a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("late write response");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  a_write_close: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_close: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !pwm_out_pin && !pwm_out_pin_oe)
    else $error("outputs active in reset");
  a_sleep_still: assert property (asleep |-> $stable(pwm_out_pin))
    else $error("pin moved in sleep");
endmodule // standard_pwm_sva

// ===== verif/pwm_load_model.sv
// Load on the output pin that times the pulses it receives
`timescale 1ns/1ps
module pwm_load_model
(
  input wire aclk,
  input wire pin,
  input wire oe,
  output logic [11:0] high_len,
  output logic [11:0] per_len
);
  logic lvl_q = 1'b0;
  logic [11:0] hc = 12'h000;
  logic [11:0] pc = 12'h000;
  // An undriven pin is pulled low at the load
  wire lvl = oe ? pin : 1'b0;
  // Period and high time from one rising edge to the next
  always @(posedge aclk)
  begin
    lvl_q <= lvl;
    pc <= (lvl && !lvl_q) ? 12'h001 : pc + 12'h001;
    hc <= (lvl && !lvl_q) ? 12'h001 : hc + {11'h000, lvl};
    if (lvl && !lvl_q)
    begin
      per_len <= pc;
      high_len <= hc;
    end
  end
endmodule // pwm_load_model

// ===== verif/tb_standard_pwm_timer_compare.sv
// Self-checking bench for the standard PWM block
`timescale 1ns/1ps
`include "pwm_map.vh"
module tb_standard_pwm_timer_compare;
  logic aclk, aresetn, sleep, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin, oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, w;
  logic [1:0] bresp, rresp;
  logic [11:0] high_len, per_len;
  int failures, compares, cyc;
  // ==========================================================
  // Clock, design and load
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  standard_pwm u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep(sleep), .pwm_out_pin(pin),
    .pwm_out_pin_oe(oe));
  pwm_load_model u_load (.aclk(aclk), .pin(pin), .oe(oe),
    .high_len(high_len), .per_len(per_len));
  // Cuts a hung run short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      summarize();
    end
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %0t seen %h wanted %h", $time, s, e);
    end
  endtask
  // Places past the last register answer with an error
  function automatic logic [1:0] resp(input logic [7:0] a);
    return a > `OFS_PORT_LATCH ? `RESP_SLVERR : `RESP_OKAY;
  endfunction
  task automatic wr(input logic [7:0] a, d);
    bit got;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        bready <= 1'b0;
        got = 1;
        check(bresp, resp(a));
      end
    end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    bit got;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rready <= 1'b0;
        got = 1;
        v = rdata;
        check(rresp, resp(a));
      end
    end
    @(posedge aclk);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(v, e);
  endtask
  // Setup in order, enabling the driver only after a timer match
  task automatic start(input logic [7:0] p, t, input logic [9:0] d);
    wr(`OFS_TIMER_CONTROL, 8'h00);
    wr(`OFS_PIN_DIRECTION, 8'h01);
    wr(`OFS_PERIOD_LIMIT, p);
    wr(`OFS_PWM_CONTROL, {2'h0, d[1:0], 4'hC});
    wr(`OFS_DUTY_WRITE, d[9:2]);
    wr(`OFS_TIMER_COUNT, 8'h00);
    wr(`OFS_IRQ_FLAGS, 8'h00);
    wr(`OFS_TIMER_CONTROL, t);
    v = 32'h0;
    while (v[`TIMER_MATCH_BIT] !== 1'b1)
      rd(`OFS_IRQ_FLAGS);
    wr(`OFS_PIN_DIRECTION, 8'h00);
    check(oe, 1'b1);
  endtask
  task automatic meas(input int p, h);
    repeat (3 * p + 8) @(posedge aclk);
    check(per_len, p);
    check(high_len, h);
  endtask
  task automatic hold(input logic l);
    repeat (32)
    begin
      @(posedge aclk);
      check(pin, l);
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk(`OFS_PERIOD_LIMIT, 32'hFF);
    chk(`OFS_PIN_DIRECTION, 32'h01);
    chk(`OFS_PWM_CONTROL, 32'h00);
    chk(8'h30, 32'h00);
    wr(8'h30, 8'h5A);
    check(oe, 1'b0);
  endtask
  // Each prescale ratio, a postscale that must not matter, full range
  task automatic t_rates;
    for (int i = 0; i < 3; i++)
    begin
      start(8'h03, {1'b0, 4'h3, 1'b1, i[1:0]}, 10'h006);
      meas(16 << (2 * i), 6 << (2 * i));
    end
    start(8'hFF, 8'h04, 10'h3FF);
    meas(1024, 1023);
  endtask
  // New duty written just after a period start waits for the next one
  task automatic t_buffer;
    @(posedge pin);
    @(posedge aclk);
    wr(`OFS_DUTY_WRITE, 8'h40);
    wr(`OFS_PWM_CONTROL, 8'h1C);
    wr(`OFS_DUTY_SHADOW, 8'h55);
    chk(`OFS_DUTY_SHADOW, 32'hFF);
    meas(1024, 257);
  endtask
  task automatic t_sleep;
    sleep <= 1'b1;
    rd(`OFS_TIMER_COUNT);
    w = v;
    repeat (40) @(posedge aclk);
    chk(`OFS_TIMER_COUNT, w);
    sleep <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(`OFS_TIMER_COUNT);
    check(v == w, 1'b0);
  endtask
  // Stopped timer, zero duty and a duty longer than the period
  task automatic t_edges;
    wr(`OFS_TIMER_CONTROL, 8'h00);
    rd(`OFS_TIMER_COUNT);
    w = v;
    repeat (40) @(posedge aclk);
    chk(`OFS_TIMER_COUNT, w);
    start(8'h03, 8'h04, 10'h000);
    hold(1'b0);
    start(8'h00, 8'h04, 10'h006);
    hold(1'b1);
  endtask
  task automatic t_release;
    wr(`OFS_PWM_CONTROL, 8'h00);
    repeat (2) @(posedge aclk);
    check(pin, 1'b0);
    wr(`OFS_PORT_LATCH, 8'h01);
    repeat (2) @(posedge aclk);
    check(pin, 1'b1);
  endtask
  task automatic summarize;
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    {sleep, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_rates();
    t_buffer();
    t_sleep();
    t_edges();
    t_release();
    summarize();
  end
endmodule // tb_standard_pwm_timer_compare
bind standard_pwm standard_pwm_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep(sleep),
  .pwm_out_pin(pwm_out_pin), .pwm_out_pin_oe(pwm_out_pin_oe));
